// File: common/adpcm_cmd_pkg.sv
// Package for the ADPCM channel command decoder: header codes, field positions,
// reset values and the per half channel settings record.
// Assumes a single system clock domain; nothing here holds logic.
`default_nettype none

package adpcm_cmd_pkg;

	// Number of half channels served
	localparam int NUM_HALF_CH = 8;

	// Upper six bits of a command's first byte
	localparam logic [5:0] HDR_SETUP  = 6'h00;
	localparam logic [5:0] HDR_PCC    = 6'h0c;
	localparam logic [5:0] HDR_PWR_UP = 6'h04;
	localparam logic [5:0] HDR_PWR_DN = 6'h02;

	// Setup record: seven bytes per half channel, only the first two are decoded here
	localparam logic [2:0] SETUP_REC_LAST = 3'h6;
	localparam int SETUP_IN_BIT    = 7;
	localparam int SETUP_OUT_BIT   = 6;
	localparam int SETUP_ALLOC_BIT = 4;
	localparam int SETUP_DEC_BIT   = 6;
	localparam int SETUP_RATE_LSB  = 0;

	// Per-channel control low byte
	localparam int PCC_RESET_BIT  = 4;
	localparam int PCC_BYPASS_BIT = 3;
	localparam int PCC_LAW_BIT    = 2;
	localparam int PCC_IDLE_BIT   = 0;

	// Route field: bit 1 input on Y, bit 0 output on Y
	typedef enum logic [1:0] {
		ROUTE_XIN_XOUT = 2'b00,
		ROUTE_XIN_YOUT = 2'b01,
		ROUTE_YIN_XOUT = 2'b10,
		ROUTE_YIN_YOUT = 2'b11
	} route_t;

	typedef enum logic [1:0] {
		RATE_16K = 2'b00,
		RATE_24K = 2'b01,
		RATE_32K = 2'b10,
		RATE_40K = 2'b11
	} rate_t;

	typedef struct packed {
		route_t route;
		logic   alloc;
		logic   decode;
		rate_t  rate;
		logic   alg_reset;
		logic   bypass;
		logic   law_a;
		logic   idle;
	} chan_cfg_t;

	// Reset values
	localparam logic  RST_ALLOC     = 1'b1;
	localparam rate_t RST_RATE      = RATE_32K;
	localparam logic  RST_ALG_RESET = 1'b1;
	localparam logic  RST_BYPASS    = 1'b0;
	localparam logic  RST_LAW_A     = 1'b0;
	localparam logic  RST_IDLE      = 1'b0;

	// Codes driven while a channel's algorithm is held in reset
	localparam logic [7:0] HOLD_CODE_ENC    = 8'hff;
	localparam logic [7:0] HOLD_CODE_DEC_MU = 8'hff;
	localparam logic [7:0] HOLD_CODE_DEC_A  = 8'hd5;

endpackage

`default_nettype wire

// File: src/adpcm_channel_command_decoder.sv
// Command decoder for the 3-wire serial command port of the ADPCM processor.
// Assumes the controller frames each command with one select-active period and
// that serial clock, data and select are slow against CLOCK (125 MHz).
`default_nettype none

module adpcm_channel_command_decoder
	import adpcm_cmd_pkg::*;
#(
	parameter int NUM_CH = NUM_HALF_CH
) (
	// Clock and reset
	input  wire logic                   CLOCK,
	input  wire logic                   RST_B,
	// Serial command port
	input  wire logic                   COMMAND_SERIAL_CLK,
	input  wire logic                   COMMAND_SERIAL_IN,
	input  wire logic                   COMMAND_SELECT_N,
	// Chip identity straps
	input  wire logic                   CHIP_ID_HIGH,
	input  wire logic                   CHIP_ID_LOW,
	// Processing control
	input  wire logic                   PROCESSING_RESUME,
	output logic                        PROCESSING_STOP,
	output logic                        PLL_POWERUP,
	output logic                        LOW_RATE_CLOCK_SEL,
	// Channel settings
	output chan_cfg_t [NUM_CH-1:0]      CHAN_CFG,
	output logic [NUM_CH-1:0][7:0]      HOLD_CODE
);

	if (NUM_CH < 1 || NUM_CH > 255) begin : g_check
		$error("NUM_CH must lie between 1 and 255");
	end

	typedef enum logic [2:0] {
		ST_HEADER   = 3'b000,
		ST_START_CH = 3'b001,
		ST_PCC_HIGH = 3'b010,
		ST_PCC_LOW  = 3'b011,
		ST_SETUP    = 3'b100,
		ST_DISCARD  = 3'b101
	} state_t;

	function automatic chan_cfg_t default_cfg(input int idx);
		chan_cfg_t c;
		c.decode    = (idx < NUM_CH / 2);
		c.route     = c.decode ? ROUTE_YIN_YOUT : ROUTE_XIN_XOUT;
		c.alloc     = RST_ALLOC;
		c.rate      = RST_RATE;
		c.alg_reset = RST_ALG_RESET;
		c.bypass    = RST_BYPASS;
		c.law_a     = RST_LAW_A;
		c.idle      = RST_IDLE;
		return c;
	endfunction

	function automatic logic [7:0] hold_code_of(input chan_cfg_t c);
		if (!c.decode)
			return HOLD_CODE_ENC;
		return c.law_a ? HOLD_CODE_DEC_A : HOLD_CODE_DEC_MU;
	endfunction

	// Pin synchronisers: two flops before any logic looks at a pin
	logic [4:0] pin_meta_reg;
	logic [4:0] pin_sync_reg;
	logic       sclk_prev_reg;
	logic       sclk_s;
	logic       sdi_s;
	logic       sel_n_s;
	logic [1:0] chip_id_s;

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			pin_meta_reg  <= 5'h1c;
			pin_sync_reg  <= 5'h1c;
			sclk_prev_reg <= 1'b0;
		end else begin
			pin_meta_reg  <= {COMMAND_SELECT_N, CHIP_ID_HIGH, CHIP_ID_LOW,
				COMMAND_SERIAL_CLK, COMMAND_SERIAL_IN};
			pin_sync_reg  <= pin_meta_reg;
			sclk_prev_reg <= pin_sync_reg[1];
		end
	end

	assign sel_n_s   = pin_sync_reg[4];
	assign chip_id_s = pin_sync_reg[3:2];
	assign sclk_s    = pin_sync_reg[1];
	assign sdi_s     = pin_sync_reg[0];

	// Byte assembly, MSB first, data taken on the serial clock's rising edge
	logic [2:0] bit_cnt_reg;
	logic [2:0] bit_cnt_next;
	logic [6:0] shift_reg;
	logic [6:0] shift_next;
	logic [7:0] byte_reg;
	logic [7:0] byte_next;
	logic       byte_stb_reg;
	logic       byte_stb_next;

	always_comb begin
		bit_cnt_next  = bit_cnt_reg;
		shift_next    = shift_reg;
		byte_next     = byte_reg;
		byte_stb_next = 1'b0;
		if (sel_n_s) begin
			bit_cnt_next = 3'h0;
		end else if (sclk_s && !sclk_prev_reg) begin
			shift_next   = {shift_reg[5:0], sdi_s};
			bit_cnt_next = bit_cnt_reg + 3'h1;
			if (bit_cnt_reg == 3'h7) begin
				byte_stb_next = 1'b1;
				byte_next     = {shift_reg, sdi_s};
			end
		end
	end

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			bit_cnt_reg  <= 3'h0;
			shift_reg    <= 7'h00;
			byte_reg     <= 8'h00;
			byte_stb_reg <= 1'b0;
		end else begin
			bit_cnt_reg  <= bit_cnt_next;
			shift_reg    <= shift_next;
			byte_reg     <= byte_next;
			byte_stb_reg <= byte_stb_next;
		end
	end

	// Command interpretation
	state_t                  state_reg;
	state_t                  state_next;
	logic [7:0]              ch_idx_reg;
	logic [7:0]              ch_idx_next;
	logic [2:0]              rec_cnt_reg;
	logic [2:0]              rec_cnt_next;
	logic [7:0]              pend0_reg;
	logic [7:0]              pend0_next;
	logic [7:0]              pend1_reg;
	logic [7:0]              pend1_next;
	chan_cfg_t [NUM_CH-1:0]  cfg_reg;
	chan_cfg_t [NUM_CH-1:0]  cfg_next;
	logic [NUM_CH-1:0][7:0]  hold_reg;
	logic [NUM_CH-1:0][7:0]  hold_next;
	logic                    powerup_reg;
	logic                    powerup_next;
	logic                    stop_reg;
	logic                    stop_next;
	logic                    lowclk_reg;
	logic                    lowclk_next;
	logic                    id_match;
	logic [5:0]              hdr;
	logic [7:0]              ch_inc;

	assign id_match = (byte_reg[1:0] == chip_id_s);
	assign hdr      = byte_reg[7:2];
	// Saturate so a runaway sequence never wraps back onto channel 0
	assign ch_inc   = (ch_idx_reg == 8'hff) ? ch_idx_reg : ch_idx_reg + 8'h01;

	always_comb begin
		state_next   = state_reg;
		ch_idx_next  = ch_idx_reg;
		rec_cnt_next = rec_cnt_reg;
		pend0_next   = pend0_reg;
		pend1_next   = pend1_reg;
		cfg_next     = cfg_reg;
		powerup_next = 1'b0;
		lowclk_next  = lowclk_reg;
		// A stop request in the same cycle as a resume wins below
		stop_next    = PROCESSING_RESUME ? 1'b0 : stop_reg;
		if (byte_stb_reg) begin
			unique case (state_reg)
				ST_HEADER: begin
					if (!id_match) begin
						state_next = ST_DISCARD;
					end else begin
						unique case (hdr)
							HDR_SETUP: begin
								ch_idx_next  = 8'h00;
								rec_cnt_next = 3'h0;
								state_next   = ST_SETUP;
							end
							HDR_PCC: state_next = ST_START_CH;
							HDR_PWR_UP: begin
								powerup_next = 1'b1;
								stop_next    = 1'b1;
								lowclk_next  = 1'b0;
								for (int i = 0; i < NUM_CH; i++)
									cfg_next[i].alg_reset = 1'b1;
								state_next = ST_DISCARD;
							end
							HDR_PWR_DN: begin
								stop_next   = 1'b1;
								lowclk_next = 1'b1;
								state_next  = ST_DISCARD;
							end
							default: state_next = ST_DISCARD;
						endcase
					end
				end
				ST_START_CH: begin
					ch_idx_next = byte_reg;
					state_next  = ST_PCC_HIGH;
				end
				ST_PCC_HIGH: state_next = ST_PCC_LOW;
				ST_PCC_LOW: begin
					for (int i = 0; i < NUM_CH; i++) begin
						if (ch_idx_reg == 8'(i)) begin
							cfg_next[i].alg_reset = byte_reg[PCC_RESET_BIT];
							cfg_next[i].bypass    = byte_reg[PCC_BYPASS_BIT];
							cfg_next[i].law_a     = byte_reg[PCC_LAW_BIT];
							cfg_next[i].idle      = byte_reg[PCC_IDLE_BIT];
						end
					end
					ch_idx_next = ch_inc;
					state_next  = ST_PCC_HIGH;
				end
				ST_SETUP: begin
					// Commit only on a whole record, so the footer byte is dropped
					if (rec_cnt_reg == 3'h0)
						pend0_next = byte_reg;
					if (rec_cnt_reg == 3'h1)
						pend1_next = byte_reg;
					if (rec_cnt_reg == SETUP_REC_LAST) begin
						for (int i = 0; i < NUM_CH; i++) begin
							if (ch_idx_reg == 8'(i)) begin
								cfg_next[i].route = route_t'({pend0_reg[SETUP_IN_BIT],
									pend0_reg[SETUP_OUT_BIT]});
								cfg_next[i].alloc  = pend0_reg[SETUP_ALLOC_BIT];
								cfg_next[i].decode = pend1_reg[SETUP_DEC_BIT];
								cfg_next[i].rate   = rate_t'(pend1_reg[SETUP_RATE_LSB +: 2]);
							end
						end
						ch_idx_next  = ch_inc;
						rec_cnt_next = 3'h0;
					end else begin
						rec_cnt_next = rec_cnt_reg + 3'h1;
					end
				end
				ST_DISCARD: state_next = ST_DISCARD;
				default: state_next = ST_HEADER;
			endcase
		end
		if (sel_n_s)
			state_next = ST_HEADER;
		for (int i = 0; i < NUM_CH; i++)
			hold_next[i] = hold_code_of(cfg_next[i]);
	end

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			state_reg   <= ST_HEADER;
			ch_idx_reg  <= 8'h00;
			rec_cnt_reg <= 3'h0;
			pend0_reg   <= 8'h00;
			pend1_reg   <= 8'h00;
			powerup_reg <= 1'b0;
			stop_reg    <= 1'b0;
			lowclk_reg  <= 1'b0;
			for (int i = 0; i < NUM_CH; i++) begin
				cfg_reg[i]  <= default_cfg(i);
				hold_reg[i] <= hold_code_of(default_cfg(i));
			end
		end else begin
			state_reg   <= state_next;
			ch_idx_reg  <= ch_idx_next;
			rec_cnt_reg <= rec_cnt_next;
			pend0_reg   <= pend0_next;
			pend1_reg   <= pend1_next;
			powerup_reg <= powerup_next;
			stop_reg    <= stop_next;
			lowclk_reg  <= lowclk_next;
			cfg_reg     <= cfg_next;
			hold_reg    <= hold_next;
		end
	end

	assign CHAN_CFG           = cfg_reg;
	assign HOLD_CODE          = hold_reg;
	assign PLL_POWERUP        = powerup_reg;
	assign PROCESSING_STOP    = stop_reg;
	assign LOW_RATE_CLOCK_SEL = lowclk_reg;

	// Checks
	logic hdr_stb;
	assign hdr_stb = byte_stb_reg && (state_reg == ST_HEADER) && !sel_n_s;

	property p_foreign_id;
		@(posedge CLOCK) disable iff (!RST_B)
		hdr_stb && !id_match |=> state_reg == ST_DISCARD && $stable(cfg_reg);
	endproperty
	a_foreign_id: assert property (p_foreign_id) else $error("foreign command accepted");

	property p_powerup;
		@(posedge CLOCK) disable iff (!RST_B)
		hdr_stb && id_match && hdr == HDR_PWR_UP |=>
			PLL_POWERUP && PROCESSING_STOP && !LOW_RATE_CLOCK_SEL && CHAN_CFG[0].alg_reset
			##1 !PLL_POWERUP;
	endproperty
	a_powerup: assert property (p_powerup) else $error("power-up command misdecoded");

	property p_powerdown;
		@(posedge CLOCK) disable iff (!RST_B)
		hdr_stb && id_match && hdr == HDR_PWR_DN |=>
			PROCESSING_STOP && LOW_RATE_CLOCK_SEL && !PLL_POWERUP;
	endproperty
	a_powerdown: assert property (p_powerdown) else $error("power-down command misdecoded");

	property p_pcc_enter;
		@(posedge CLOCK) disable iff (!RST_B)
		hdr_stb && id_match && hdr == HDR_PCC |=> state_reg == ST_START_CH;
	endproperty
	a_pcc_enter: assert property (p_pcc_enter) else $error("control header not taken");

	property p_start_ch;
		@(posedge CLOCK) disable iff (!RST_B)
		byte_stb_reg && state_reg == ST_START_CH && !sel_n_s |=>
			ch_idx_reg == $past(byte_reg) && state_reg == ST_PCC_HIGH;
	endproperty
	a_start_ch: assert property (p_start_ch) else $error("start channel not loaded");

	property p_pcc_low;
		@(posedge CLOCK) disable iff (!RST_B)
		byte_stb_reg && state_reg == ST_PCC_LOW && ch_idx_reg == 8'h00 |=>
			CHAN_CFG[0].alg_reset == $past(byte_reg[PCC_RESET_BIT]) &&
			CHAN_CFG[0].bypass == $past(byte_reg[PCC_BYPASS_BIT]) &&
			CHAN_CFG[0].law_a == $past(byte_reg[PCC_LAW_BIT]) &&
			CHAN_CFG[0].idle == $past(byte_reg[PCC_IDLE_BIT]) && ch_idx_reg == 8'h01;
	endproperty
	a_pcc_low: assert property (p_pcc_low) else $error("control low byte not applied");

	property p_setup_commit;
		@(posedge CLOCK) disable iff (!RST_B)
		byte_stb_reg && state_reg == ST_SETUP && rec_cnt_reg == SETUP_REC_LAST &&
			ch_idx_reg == 8'h00 |=>
			CHAN_CFG[0].decode == $past(pend1_reg[SETUP_DEC_BIT]) &&
			CHAN_CFG[0].alloc == $past(pend0_reg[SETUP_ALLOC_BIT]) &&
			CHAN_CFG[0].route[1] == $past(pend0_reg[SETUP_IN_BIT]) && rec_cnt_reg == 3'h0;
	endproperty
	a_setup_commit: assert property (p_setup_commit) else $error("setup record not applied");

	// Checked on every channel, since the A-law decoder may sit anywhere
	property p_hold_code(int ch);
		@(posedge CLOCK) disable iff (!RST_B)
		CHAN_CFG[ch].decode && CHAN_CFG[ch].law_a |-> HOLD_CODE[ch] == 8'hd5;
	endproperty
	for (genvar g = 0; g < NUM_CH; g++) begin : g_hold_chk
		a_hold_code: assert property (p_hold_code(g)) else $error("A-law hold code wrong");
	end

	property p_frame_end;
		@(posedge CLOCK) disable iff (!RST_B)
		sel_n_s |=> state_reg == ST_HEADER && bit_cnt_reg == 3'h0;
	endproperty
	a_frame_end: assert property (p_frame_end) else $error("frame end not honoured");

	c_powerup: cover property (@(posedge CLOCK) disable iff (!RST_B) PLL_POWERUP);
	c_powerdown: cover property (@(posedge CLOCK) disable iff (!RST_B) $rose(LOW_RATE_CLOCK_SEL));
	c_pcc_last: cover property (@(posedge CLOCK) disable iff (!RST_B)
		byte_stb_reg && state_reg == ST_PCC_LOW && ch_idx_reg == 8'(NUM_CH - 1));
	c_setup: cover property (@(posedge CLOCK) disable iff (!RST_B)
		byte_stb_reg && state_reg == ST_SETUP && rec_cnt_reg == SETUP_REC_LAST);

endmodule

`default_nettype wire

// File: verif/cmd_port_master.sv
// Behavioural controller on the three-wire serial command port.
// Assumes the bench clock paces every edge it makes; serial clock idles low.
`default_nettype none

module cmd_port_master (
	// Pacing clock
	input  wire logic clk,
	// Three-wire command port
	output logic      sclk,
	output logic      sdata,
	output logic      sel_n
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		sclk  = 1'b0;
		sdata = 1'b1;
		sel_n = 1'b1;
	end

	// Six cycles per phase keeps well clear of the synchroniser minimum
	task automatic half_bit();
		repeat (6) @(posedge clk);
		#1;
	endtask

	// One command per select frame, bits MSB first, data changes only while sclk is low
	task automatic send_frame(input logic [7:0] q[$]);
		@(posedge clk);
		#1 sel_n = 1'b0;
		foreach (q[i]) begin
			for (int b = 7; b >= 0; b--) begin
				half_bit();
				sclk  = 1'b0;
				sdata = q[i][b];
				half_bit();
				sclk = 1'b1;
			end
		end
		half_bit();
		sclk = 1'b0;
		repeat (8) @(posedge clk);
		#1 sel_n = 1'b1;
		// Released data line must not look like a held bit
		sdata = ~sdata;
	endtask

endmodule

`default_nettype wire

// File: verif/adpcm_channel_command_decoder_tb.sv
// Self-checking bench for the channel command decoder.
// Assumes the controller model frames every command; straps fixed to one chip ID.
`default_nettype none

module adpcm_channel_command_decoder_tb import adpcm_cmd_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [1:0] MY_ID = 2'b10;

	logic                        clock;
	logic                        rst_b;
	logic                        resume;
	logic                        sclk;
	logic                        sdata;
	logic                        sel_n;
	logic                        stop;
	logic                        pll_up;
	logic                        low_rate;
	chan_cfg_t [NUM_HALF_CH-1:0] chan_cfg;
	logic [NUM_HALF_CH-1:0][7:0] hold_code;
	chan_cfg_t                   exp_cfg [NUM_HALF_CH];
	int                          mismatches = 0;
	int                          checked = 0;
	int                          pll_pulses = 0;

	adpcm_channel_command_decoder adpcm_channel_command_decoder_i (
		.CLOCK              (clock),
		.RST_B              (rst_b),
		.COMMAND_SERIAL_CLK (sclk),
		.COMMAND_SERIAL_IN  (sdata),
		.COMMAND_SELECT_N   (sel_n),
		.CHIP_ID_HIGH       (MY_ID[1]),
		.CHIP_ID_LOW        (MY_ID[0]),
		.PROCESSING_RESUME  (resume),
		.PROCESSING_STOP    (stop),
		.PLL_POWERUP        (pll_up),
		.LOW_RATE_CLOCK_SEL (low_rate),
		.CHAN_CFG           (chan_cfg),
		.HOLD_CODE          (hold_code)
	);

	cmd_port_master cmd_port_master_i (
		.clk   (clock),
		.sclk  (sclk),
		.sdata (sdata),
		.sel_n (sel_n)
	);

	always #4 clock = ~clock;

	// Pulse width shows up as extra counts
	always @(posedge clock) begin
		if (pll_up === 1'b1) pll_pulses++;
	end

	task automatic close_out();
		if (mismatches == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] expd);
		checked++;
		if (seen !== expd) begin
			mismatches++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, expd);
		end
	endtask

	function automatic chan_cfg_t reset_cfg(input int ch);
		chan_cfg_t c;
		c = '0;
		c.route     = (ch < 4) ? ROUTE_YIN_YOUT : ROUTE_XIN_XOUT;
		c.decode    = (ch < 4);
		c.alloc     = 1'b1;
		c.rate      = RATE_32K;
		c.alg_reset = 1'b1;
		return c;
	endfunction

	function automatic logic [7:0] hold_of(input chan_cfg_t c);
		return (c.decode && c.law_a) ? 8'hd5 : 8'hff;
	endfunction

	task automatic check_all();
		for (int ch = 0; ch < NUM_HALF_CH; ch++) begin
			check({6'h00, chan_cfg[ch]}, {6'h00, exp_cfg[ch]});
			check({8'h00, hold_code[ch]}, {8'h00, hold_of(exp_cfg[ch])});
		end
	endtask

	task automatic settle();
		repeat (4) @(posedge clock);
		#1;
	endtask

	task automatic test_reset();
		for (int ch = 0; ch < NUM_HALF_CH; ch++) exp_cfg[ch] = reset_cfg(ch);
		check_all();
		check({13'h0000, stop, pll_up, low_rate}, 16'h0000);
	endtask

	// Four records cover every route and rate code, then a footer byte
	task automatic test_setup();
		logic [7:0] q[$];
		q = '{{6'b000000, MY_ID}};
		for (int k = 0; k < 4; k++) begin
			exp_cfg[k].route  = route_t'(k[1:0]);
			exp_cfg[k].alloc  = k[0];
			exp_cfg[k].decode = k[1] ^ k[0];
			exp_cfg[k].rate   = rate_t'(~k[1:0]);
			q.push_back({k[1], k[0], 1'b0, k[0], 4'h0});
			q.push_back({1'b0, k[1] ^ k[0], 1'b0, 3'b111, ~k[1:0]});
			repeat (5) q.push_back(8'h00);
		end
		q.push_back(8'h01);
		cmd_port_master_i.send_frame(q);
		settle();
		check_all();
	endtask

	// Start at channel 2; one decoder picks A-law to reach the d5 hold code
	task automatic test_control();
		logic [7:0] lows [4];
		logic [7:0] q[$];
		lows = '{8'h0c, 8'h15, 8'h10, 8'h01};
		q = '{{6'b001100, MY_ID}, 8'h02};
		for (int k = 0; k < 4; k++) begin
			q.push_back(8'h00);
			q.push_back(lows[k]);
			exp_cfg[k + 2].alg_reset = lows[k][4];
			exp_cfg[k + 2].bypass    = lows[k][3];
			exp_cfg[k + 2].law_a     = lows[k][2];
			exp_cfg[k + 2].idle      = lows[k][0];
		end
		cmd_port_master_i.send_frame(q);
		settle();
		check_all();
	endtask

	task automatic test_refused();
		logic [7:0] q[$];
		q = '{{6'b001100, ~MY_ID}, 8'h00, 8'h00, 8'h1d};
		cmd_port_master_i.send_frame(q);
		q = '{{6'b010000, MY_ID}, 8'h00, 8'h00, 8'h1d};
		cmd_port_master_i.send_frame(q);
		settle();
		check_all();
		q = '{{6'b001100, MY_ID}, 8'h05, 8'h00, 8'h00};
		cmd_port_master_i.send_frame(q);
		exp_cfg[5].idle = 1'b0;
		settle();
		check_all();
		// Channel zero encoder picks A-law: hold code must stay ff
		q = '{{6'b001100, MY_ID}, 8'h00, 8'h00, 8'h04};
		cmd_port_master_i.send_frame(q);
		exp_cfg[0].alg_reset = 1'b0;
		exp_cfg[0].bypass    = 1'b0;
		exp_cfg[0].law_a     = 1'b1;
		exp_cfg[0].idle      = 1'b0;
		settle();
		check_all();
	endtask

	// Power-down with a stray power-up byte in the same frame, then power-up
	task automatic test_power();
		logic [7:0] q[$];
		q = '{{6'b000010, MY_ID}, {6'b000100, MY_ID}};
		cmd_port_master_i.send_frame(q);
		settle();
		check({13'h0000, stop, pll_up, low_rate}, 16'h0005);
		check(pll_pulses[15:0], 16'h0000);
		@(posedge clock);
		#1 resume = 1'b1;
		@(posedge clock);
		#1 resume = 1'b0;
		@(posedge clock);
		#1;
		check({13'h0000, stop, pll_up, low_rate}, 16'h0001);
		q = '{{6'b000100, MY_ID}};
		cmd_port_master_i.send_frame(q);
		settle();
		for (int ch = 0; ch < NUM_HALF_CH; ch++) exp_cfg[ch].alg_reset = 1'b1;
		check({13'h0000, stop, pll_up, low_rate}, 16'h0004);
		check(pll_pulses[15:0], 16'h0001);
		check_all();
	endtask

	initial begin
		clock  = 1'b0;
		rst_b  = 1'b0;
		resume = 1'b0;
		repeat (6) @(posedge clock);
		#1 rst_b = 1'b1;
		repeat (5) @(posedge clock);
		#1;
		test_reset();
		test_setup();
		test_control();
		test_refused();
		test_power();
		close_out();
	end

	// About six times the expected run length
	initial begin
		#300us;
		mismatches++;
		close_out();
	end

endmodule

`default_nettype wire
